// >>> eag_dec_if.sv
`timescale 1ns/1ps
interface eag_dec_if;
  import eag_pkg::*;
  logic [7:0] opcode;
  eag_mode_t mode;
  eag_ctrl_t ctrl;
  logic [1:0] len;
  logic [2:0] bit_num;
  logic bit_pol;
  logic bit_val;
  modport dec (input opcode, output mode, ctrl, len, bit_num, bit_pol, bit_val);
  modport core (output opcode, input mode, ctrl, len, bit_num, bit_pol, bit_val);
endinterface // eag_dec_if

// >>> eag_effective_address_generator.sv
`timescale 1ns/1ps
module eag_effective_address_generator
  import eag_pkg::*;
#(
  parameter int AW = ADDR_W_DEF
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [AW-1:0] pc_in,
  input wire logic [7:0] index_in,
  input wire logic cond_met,
  input wire logic [7:0] prog_data,
  input wire logic [7:0] data_rdata,
  output logic busy,
  output logic [AW-1:0] prog_addr,
  output logic prog_rd,
  output logic [AW-1:0] data_addr,
  output logic data_rd,
  output logic data_access,
  output logic done,
  output eag_mode_t mode,
  output eag_ctrl_t ctrl_op,
  output logic [1:0] instr_len,
  output logic [AW-1:0] effective_address,
  output logic [7:0] operand,
  output logic [AW-1:0] next_pc,
  output logic branch_taken,
  output logic carry_we,
  output logic carry_val,
  output logic [2:0] bit_num,
  output logic bit_value
);

  //==============================================================
  // State
  typedef struct packed {
    eag_state_t st;
    logic [AW-1:0] pc;
    logic [7:0] opc;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] x;
    logic busy;
    logic done;
    logic prd;
    logic [AW-1:0] paddr;
    logic drd;
    logic dacc;
    logic [AW-1:0] daddr;
    logic [AW-1:0] ea;
    logic [AW-1:0] npc;
    eag_mode_t mode;
    eag_ctrl_t ctrl;
    logic [1:0] len;
    logic [7:0] oper;
    logic taken;
    logic cwe;
    logic cval;
    logic [2:0] bitn;
    logic bval;
  } eag_st_t;

  eag_st_t s;
  eag_st_t n;
  logic fin;
  logic [AW-1:0] pcn;

  eag_dec_if dif ();

  eag_opcode_decoder u_dec (
    .dif(dif.dec)
  );

  // The opcode byte is decoded in the cycle it arrives, so that a
  // one-byte instruction completes without an extra cycle.
  assign dif.opcode = (s.st == S_OPC) ? prog_data : s.opc;

  //==============================================================
  // Arithmetic helpers
  function automatic logic [AW-1:0] rel_target(input logic [AW-1:0] base, input logic [7:0] off);
    return base + AW'($signed(off));
  endfunction

  function automatic logic [AW-1:0] zext8(input logic [7:0] v);
    return {{(AW-8){1'b0}}, v};
  endfunction

  function automatic logic [AW-1:0] word16(input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] w;
    w = {hi, lo};
    return AW'(w);
  endfunction

  //==============================================================
  // Sequencer
  always_comb begin
    n = s;
    fin = 1'b0;
    pcn = s.pc + AW'(s.len);
    n.done = 1'b0;
    n.prd = 1'b0;
    n.drd = 1'b0;
    n.dacc = 1'b0;
    n.cwe = 1'b0;
    case (s.st)
      S_IDLE: begin
        if (start) begin
          n.st = S_OPC;
          n.pc = pc_in;
          n.paddr = pc_in;
          n.prd = 1'b1;
          n.busy = 1'b1;
        end
      end
      S_OPC: begin
        n.opc = prog_data;
        n.x = index_in;
        if (dif.len == LEN_ONE) begin
          fin = 1'b1;
        end else begin
          n.paddr = s.pc + AW'(1);
          n.prd = 1'b1;
          n.st = S_B1;
        end
      end
      S_B1: begin
        n.b1 = prog_data;
        if (dif.len == LEN_TWO) begin
          fin = 1'b1;
        end else begin
          n.paddr = s.pc + AW'(2);
          n.prd = 1'b1;
          n.st = S_B2;
        end
      end
      S_B2: begin
        n.b2 = prog_data;
        if (dif.mode == M_BTB) begin
          n.daddr = zext8(s.b1);
          n.drd = 1'b1;
          n.st = S_BRD;
        end else begin
          fin = 1'b1;
        end
      end
      S_BRD: begin
        fin = 1'b1;
      end
      default: begin
        n.st = S_IDLE;
        n.busy = 1'b0;
      end
    endcase

    if (fin) begin
      n.st = S_IDLE;
      n.busy = 1'b0;
      n.done = 1'b1;
      n.mode = dif.mode;
      n.ctrl = dif.ctrl;
      n.len = dif.len;
      n.bitn = dif.bit_num;
      n.bval = dif.bit_val;
      n.taken = 1'b0;
      n.oper = 8'h00;
      n.ea = '0;
      pcn = s.pc + AW'(dif.len);
      n.npc = pcn;
      case (dif.mode)
        M_IMM: begin
          n.ea = s.pc + AW'(1);
          n.oper = n.b1;
        end
        M_DIR: begin
          n.ea = zext8(n.b1);
          n.dacc = 1'b1;
        end
        M_EXT: begin
          n.ea = word16(n.b1, n.b2);
          n.dacc = 1'b1;
        end
        M_REL: begin
          n.taken = cond_met;
          n.npc = cond_met ? rel_target(pcn, n.b1) : pcn;
        end
        M_IX: begin
          n.ea = zext8(n.x);
          n.dacc = 1'b1;
        end
        M_IX1: begin
          n.ea = zext8(n.x) + zext8(n.b1);
          n.dacc = 1'b1;
        end
        M_IX2: begin
          n.ea = zext8(n.x) + word16(n.b1, n.b2);
          n.dacc = 1'b1;
        end
        M_BSC: begin
          n.ea = zext8(n.b1);
          n.dacc = 1'b1;
        end
        M_BTB: begin
          // Carry is written whatever the branch outcome.
          n.ea = zext8(n.b1);
          n.cwe = 1'b1;
          n.cval = data_rdata[dif.bit_num];
          n.taken = (data_rdata[dif.bit_num] == dif.bit_pol);
          n.npc = n.taken ? rel_target(pcn, n.b2) : pcn;
        end
        default: begin
          n.ea = '0;
        end
      endcase
      if (n.dacc) begin
        n.daddr = n.ea;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  //==============================================================
  // Outputs
  assign busy = s.busy;
  assign prog_addr = s.paddr;
  assign prog_rd = s.prd;
  assign data_addr = s.daddr;
  assign data_rd = s.drd;
  assign data_access = s.dacc;
  assign done = s.done;
  assign mode = s.mode;
  assign ctrl_op = s.ctrl;
  assign instr_len = s.len;
  assign effective_address = s.ea;
  assign operand = s.oper;
  assign next_pc = s.npc;
  assign branch_taken = s.taken;
  assign carry_we = s.cwe;
  assign carry_val = s.cval;
  assign bit_num = s.bitn;
  assign bit_value = s.bval;

  //==============================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence s_go;
    s.st == S_IDLE && start;
  endsequence

  sequence s_btb_read;
    data_rd && s.st == S_BRD;
  endsequence

  AST_DONE_LATENCY: assert property (s_go |-> ##[2:5] done)
    else $error("instruction did not complete in time");

  AST_IMM: assert property (done && mode == M_IMM |->
      operand == s.b1 && effective_address == s.pc + AW'(1) && instr_len == LEN_TWO)
    else $error("immediate operand wrong");

  AST_DIR: assert property (done && mode == M_DIR |->
      effective_address == zext8(s.b1) && effective_address < AW'(DIR_SPAN) && instr_len == LEN_TWO)
    else $error("direct address wrong");

  AST_EXT: assert property (done && mode == M_EXT |->
      effective_address == AW'({s.b1, s.b2}) && instr_len == LEN_THREE)
    else $error("extended address wrong");

  AST_REL: assert property (done && mode == M_REL |->
      next_pc == (branch_taken ? s.pc + AW'(2) + AW'($signed(s.b1)) : s.pc + AW'(2)))
    else $error("relative target wrong");

  AST_REL_SPAN: assert property (done && branch_taken |->
      ($signed(next_pc - (s.pc + AW'(instr_len))) >= -128) &&
      ($signed(next_pc - (s.pc + AW'(instr_len))) <= 127))
    else $error("branch target outside span");

  AST_IX: assert property (done && mode == M_IX |->
      effective_address == {{(AW-8){1'b0}}, s.x} && instr_len == LEN_ONE)
    else $error("indexed address wrong");

  AST_IX1: assert property (done && mode == M_IX1 |->
      effective_address == AW'(s.x) + AW'(s.b1) && effective_address <= AW'(IX1_MAX))
    else $error("indexed byte offset wrong");

  AST_IX2: assert property (done && mode == M_IX2 |->
      effective_address == AW'(s.x) + AW'({s.b1, s.b2}) && instr_len == LEN_THREE)
    else $error("indexed word offset wrong");

  AST_BSC: assert property (done && mode == M_BSC |->
      bit_num == s.opc[3:1] && effective_address == zext8(s.b1) && bit_value == ~s.opc[0])
    else $error("bit set clear decode wrong");

  AST_BTB: assert property (s_btb_read ##1 1'b1 |->
      done && carry_we && carry_val == $past(data_rdata[s.opc[3:1]]) &&
      branch_taken == (carry_val == ~s.opc[0]))
    else $error("bit test carry or outcome wrong");

  AST_BTB_ADDR: assert property (s_btb_read |-> data_addr == zext8(s.b1) && $past(prog_rd, 2))
    else $error("bit test read address wrong");

  AST_INH: assert property (done && mode == M_INH |-> instr_len == LEN_ONE && !data_access)
    else $error("inherent length wrong");

  AST_CTRL: assert property (done && ctrl_op != C_NONE |-> mode == M_INH)
    else $error("control op outside inherent mode");

  AST_DACC: assert property (data_access |-> data_addr == effective_address && done)
    else $error("data address not the effective address");

endmodule // eag_effective_address_generator

// >>> eag_mem_model.sv
`timescale 1ns/1ps
// ==========================================
// Program and data memory seen by the block
module eag_mem_model (
  input wire logic clk,
  input wire logic [15:0] prog_addr,
  input wire logic prog_rd,
  input wire logic [15:0] data_addr,
  input wire logic data_rd,
  output logic [7:0] prog_data,
  output logic [7:0] data_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] idle_pat = 8'h00;

  // A read is answered while its registered strobe stands, which is where the block samples it.
  // Outside a read the bus shows a toggling pattern, so stale bytes never look valid.
  always @(posedge clk) idle_pat <= ~idle_pat;
  assign prog_data = prog_rd ? mem[prog_addr] : idle_pat;
  assign data_rdata = data_rd ? mem[data_addr] : ~idle_pat;
endmodule // eag_mem_model

// >>> eag_opcode_decoder.sv
`timescale 1ns/1ps
module eag_opcode_decoder
  import eag_pkg::*;
(
  eag_dec_if.dec dif
);

  //==============================================================
  // Mode and length from the opcode row
  always_comb begin
    dif.bit_num = dif.opcode[3:1];
    dif.bit_pol = ~dif.opcode[0];
    dif.bit_val = ~dif.opcode[0];
    dif.ctrl = C_NONE;
    dif.mode = M_INH;
    dif.len = LEN_ONE;
    case (dif.opcode[7:4])
      ROW_BTB: begin
        dif.mode = M_BTB;
        dif.len = LEN_THREE;
      end
      ROW_BSC: begin
        dif.mode = M_BSC;
        dif.len = LEN_TWO;
      end
      ROW_REL: begin
        dif.mode = M_REL;
        dif.len = LEN_TWO;
      end
      ROW_DIR_RMW, ROW_DIR: begin
        dif.mode = M_DIR;
        dif.len = LEN_TWO;
      end
      ROW_IX1_RMW, ROW_IX1: begin
        dif.mode = M_IX1;
        dif.len = LEN_TWO;
      end
      ROW_IX_RMW, ROW_IX: begin
        dif.mode = M_IX;
        dif.len = LEN_ONE;
      end
      ROW_IMM: begin
        // The subroutine branch sits in the immediate row but is relative.
        dif.mode = (dif.opcode == OPC_BSR) ? M_REL : M_IMM;
        dif.len = LEN_TWO;
      end
      ROW_EXT: begin
        dif.mode = M_EXT;
        dif.len = LEN_THREE;
      end
      ROW_IX2: begin
        dif.mode = M_IX2;
        dif.len = LEN_THREE;
      end
      default: begin
        dif.mode = M_INH;
        dif.len = LEN_ONE;
      end
    endcase
    case (dif.opcode)
      OPC_TAX: dif.ctrl = C_ACC2X;
      OPC_TXA: dif.ctrl = C_X2ACC;
      OPC_SEC: dif.ctrl = C_SETC;
      OPC_CLC: dif.ctrl = C_CLRC;
      OPC_SEI: dif.ctrl = C_SETI;
      OPC_CLI: dif.ctrl = C_CLRI;
      OPC_SWI: dif.ctrl = C_TRAP;
      OPC_RTS: dif.ctrl = C_RTS;
      OPC_RTI: dif.ctrl = C_RTI;
      OPC_RSP: dif.ctrl = C_RSP;
      OPC_NOP: dif.ctrl = C_IDLE;
      OPC_STOP: dif.ctrl = C_STOP;
      OPC_WAIT: dif.ctrl = C_WAIT;
      default: dif.ctrl = C_NONE;
    endcase
  end

endmodule // eag_opcode_decoder

// >>> eag_pkg.sv
//==============================================================
// Behaviour
// - Ten addressing modes are decoded and served.
// - Immediate operand is the byte after opcode.
// - Direct address is one byte, two-byte instruction.
// - Extended address is two bytes, three-byte instruction.
// - Signed offset added to PC only when taken.
// - Branch span is -128..+127 from next opcode.
// - Indexed no offset uses index alone, one byte.
// - Index plus unsigned byte, up to 510.
// - Index plus unsigned word, three-byte instruction.
// - Bit set/clear: bit from opcode, direct address.
// - Bit test: polarity from opcode, third-byte offset.
// - Tested bit always copied into carry flag.
// - Inherent instructions are one byte long.
// - Control group operations are all decoded.
package eag_pkg;

  localparam int ADDR_W_DEF = 16;
  localparam int DIR_SPAN = 256;
  localparam int IX1_MAX = 510;

  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  localparam logic [3:0] ROW_BTB = 4'h0;
  localparam logic [3:0] ROW_BSC = 4'h1;
  localparam logic [3:0] ROW_REL = 4'h2;
  localparam logic [3:0] ROW_DIR_RMW = 4'h3;
  localparam logic [3:0] ROW_INH_A = 4'h4;
  localparam logic [3:0] ROW_INH_X = 4'h5;
  localparam logic [3:0] ROW_IX1_RMW = 4'h6;
  localparam logic [3:0] ROW_IX_RMW = 4'h7;
  localparam logic [3:0] ROW_CTL_LO = 4'h8;
  localparam logic [3:0] ROW_CTL_HI = 4'h9;
  localparam logic [3:0] ROW_IMM = 4'hA;
  localparam logic [3:0] ROW_DIR = 4'hB;
  localparam logic [3:0] ROW_EXT = 4'hC;
  localparam logic [3:0] ROW_IX2 = 4'hD;
  localparam logic [3:0] ROW_IX1 = 4'hE;
  localparam logic [3:0] ROW_IX = 4'hF;

  localparam logic [7:0] OPC_BSR = 8'hAD;
  localparam logic [7:0] OPC_RTI = 8'h80;
  localparam logic [7:0] OPC_RTS = 8'h81;
  localparam logic [7:0] OPC_SWI = 8'h83;
  localparam logic [7:0] OPC_STOP = 8'h8E;
  localparam logic [7:0] OPC_WAIT = 8'h8F;
  localparam logic [7:0] OPC_TAX = 8'h97;
  localparam logic [7:0] OPC_CLC = 8'h98;
  localparam logic [7:0] OPC_SEC = 8'h99;
  localparam logic [7:0] OPC_CLI = 8'h9A;
  localparam logic [7:0] OPC_SEI = 8'h9B;
  localparam logic [7:0] OPC_RSP = 8'h9C;
  localparam logic [7:0] OPC_NOP = 8'h9D;
  localparam logic [7:0] OPC_TXA = 8'h9F;

  typedef enum logic [3:0] {
    M_IMM = 4'h0, M_DIR = 4'h1, M_EXT = 4'h2, M_REL = 4'h3, M_IX = 4'h4,
    M_IX1 = 4'h5, M_IX2 = 4'h6, M_BSC = 4'h7, M_BTB = 4'h8, M_INH = 4'h9
  } eag_mode_t;

  typedef enum logic [3:0] {
    C_NONE = 4'h0, C_ACC2X = 4'h1, C_X2ACC = 4'h2, C_SETC = 4'h3, C_CLRC = 4'h4,
    C_SETI = 4'h5, C_CLRI = 4'h6, C_TRAP = 4'h7, C_RTS = 4'h8, C_RTI = 4'h9,
    C_RSP = 4'hA, C_IDLE = 4'hB, C_STOP = 4'hC, C_WAIT = 4'hD
  } eag_ctrl_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_OPC = 3'h1, S_B1 = 3'h2, S_B2 = 3'h3, S_BRD = 3'h4
  } eag_state_t;

endpackage

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top
  import eag_pkg::*;
;
  typedef struct {
    eag_mode_t m;
    eag_ctrl_t c;
    logic [1:0] len;
    logic [15:0] ea;
    logic [7:0] opd;
    logic [15:0] npc;
    logic tk, cw, cv, da, bv;
    logic [2:0] bn;
  } eag_exp_t;

  logic clk, rst, ce, start, cond_met, busy, prog_rd, data_rd, data_access, done;
  logic branch_taken, carry_we, carry_val, bit_value;
  logic [15:0] pc_in, prog_addr, data_addr, effective_address, next_pc;
  logic [7:0] index_in, prog_data, data_rdata, operand;
  logic [1:0] instr_len;
  logic [2:0] bit_num;
  eag_mode_t mode;
  eag_ctrl_t ctrl_op;
  eag_exp_t exq[$];
  eag_exp_t g;
  int err_total = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'hA104;
  logic [7:0] ctl_op [13] = '{8'h97, 8'h9F, 8'h99, 8'h98, 8'h9B, 8'h9A, 8'h83, 8'h81, 8'h80, 8'h9C, 8'h9D,
    8'h8E, 8'h8F};
  eag_ctrl_t ctl_c [13] = '{C_ACC2X, C_X2ACC, C_SETC, C_CLRC, C_SETI, C_CLRI, C_TRAP, C_RTS, C_RTI, C_RSP,
    C_IDLE, C_STOP, C_WAIT};
  logic [39:0] dirs [18] = '{40'hAD810000_01, 40'hA6550000_00, 40'hB6FF0000_00, 40'hC6123400_00, 40'h20800000_01,
    40'h227F0000_01, 40'h247F0000_00, 40'hF60000FF_00, 40'hE6FF00FF_00, 40'hD6FFFFFF_00, 40'h10200000_00,
    40'h1FFF0000_00, 40'h00408000_00, 40'h0F407F00_00, 40'h4C000000_00, 40'h5F000000_00, 40'h3C100000_00,
    40'h7C000033_00};

  eag_effective_address_generator #(.AW(16)) eag_effective_address_generator_inst (.clk(clk), .rst(rst),
    .ce(ce), .start(start), .pc_in(pc_in), .index_in(index_in), .cond_met(cond_met), .prog_data(prog_data),
    .data_rdata(data_rdata), .busy(busy), .prog_addr(prog_addr), .prog_rd(prog_rd), .data_addr(data_addr),
    .data_rd(data_rd), .data_access(data_access), .done(done), .mode(mode), .ctrl_op(ctrl_op),
    .instr_len(instr_len), .effective_address(effective_address), .operand(operand), .next_pc(next_pc),
    .branch_taken(branch_taken), .carry_we(carry_we), .carry_val(carry_val), .bit_num(bit_num),
    .bit_value(bit_value));

  eag_mem_model eag_mem_model_inst (.clk(clk), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .data_addr(data_addr), .data_rd(data_rd), .prog_data(prog_data), .data_rdata(data_rdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input logic ok, input string s);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, s);
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic eag_exp_t expect_of(input logic [7:0] op, b1, b2, x, input logic c,
      input logic [15:0] p, input logic [7:0] dv);
    eag_exp_t e;
    logic [7:0] o;
    e = '{M_INH, C_NONE, LEN_ONE, 16'h0000, 8'h00, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0, ~op[0], op[3:1]};
    case (op[7:4])
      4'h0: begin
        e.m = M_BTB; e.len = LEN_THREE; e.ea = {8'h00, b1}; e.cw = 1'b1;
        e.cv = dv[op[3:1]]; e.tk = e.cv ^ op[0];
      end
      4'h1: begin e.m = M_BSC; e.len = LEN_TWO; e.ea = {8'h00, b1}; e.da = 1'b1; end
      4'h2: begin e.m = M_REL; e.len = LEN_TWO; e.tk = c; end
      4'h3, 4'hB: begin e.m = M_DIR; e.len = LEN_TWO; e.ea = {8'h00, b1}; e.da = 1'b1; end
      4'h6, 4'hE: begin e.m = M_IX1; e.len = LEN_TWO; e.ea = {8'h00, x} + {8'h00, b1}; e.da = 1'b1; end
      4'h7, 4'hF: begin e.m = M_IX; e.ea = {8'h00, x}; e.da = 1'b1; end
      4'hA: if (op == 8'hAD) begin e.m = M_REL; e.len = LEN_TWO; e.tk = c; end
        else begin e.m = M_IMM; e.len = LEN_TWO; e.ea = p + 16'h0001; e.opd = b1; end
      4'hC: begin e.m = M_EXT; e.len = LEN_THREE; e.ea = {b1, b2}; e.da = 1'b1; end
      4'hD: begin e.m = M_IX2; e.len = LEN_THREE; e.ea = {b1, b2} + {8'h00, x}; e.da = 1'b1; end
      default: for (int i = 0; i < 13; i++) if (ctl_op[i] == op) e.c = ctl_c[i];
    endcase
    o = (e.len == LEN_THREE) ? b2 : b1;
    e.npc = p + {14'h0000, e.len} + (e.tk ? {{8{o[7]}}, o} : 16'h0000);
    return e;
  endfunction

  // Called just after an edge; leaves just after the edge that shows done.
  task automatic run(input logic [7:0] op, b1, b2, x, input logic c);
    logic [15:0] p;
    int n;
    int lat;
    seed = xs(seed);
    p = 16'h1000 | {4'h0, seed[11:0]};
    eag_mem_model_inst.mem[p] = op;
    eag_mem_model_inst.mem[p + 16'h0001] = b1;
    eag_mem_model_inst.mem[p + 16'h0002] = b2;
    eag_mem_model_inst.mem[{8'h00, b1}] = seed[23:16];
    exq.push_back(expect_of(op, b1, b2, x, c, p, seed[23:16]));
    lat = (op[7:4] == 4'h0) ? 4 : int'(exq[$].len);
    pc_in = p;
    index_in = x;
    cond_met = c;
    start = 1'b1;
    n = 0;
    @(posedge clk);
    #2;
    pc_in = ~p;
    start = 1'b0;
    // A random two-cycle clock-enable stall must stretch the latency by exactly two edges.
    if (seed[24]) begin
      ce = 1'b0;
      lat = lat + 2;
    end
    chk(busy === 1'b1, "busy after start");
    while (done !== 1'b1 && n < 9) begin
      @(posedge clk);
      #2;
      n++;
      if (n == 2) ce = 1'b1;
    end
    if (done !== 1'b1) begin
      chk(1'b0, "no completion");
      close_out();
    end
    chk(n == lat, "completion latency");
  endtask

  // ==========================================
  // Result watcher
  always @(posedge clk) begin
    #3;
    if (done === 1'b1) begin
      if (exq.size() == 0) chk(1'b0, "completion without request");
      else begin
        g = exq.pop_front();
        chk(mode === g.m, "mode");
        chk(ctrl_op === g.c, "control operation");
        chk(instr_len === g.len, "length");
        chk(effective_address === g.ea, "effective address");
        chk(operand === g.opd, "immediate operand");
        chk(next_pc === g.npc, "next pc");
        chk(branch_taken === g.tk, "branch outcome");
        chk(carry_we === g.cw, "carry write");
        if (g.cw === 1'b1) chk(carry_val === g.cv, "carry value");
        chk(data_access === g.da && (g.da !== 1'b1 || data_addr === g.ea), "data access");
        if (g.m == M_BSC || g.m == M_BTB) chk(bit_num === g.bn, "bit number");
        if (g.m == M_BSC) chk(bit_value === g.bv, "bit sense");
      end
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    logic [7:0] op;
    rst = 1'b1;
    ce = 1'b1;
    start = 1'b0;
    pc_in = 16'h0000;
    index_in = 8'h00;
    cond_met = 1'b0;
    repeat (12) @(posedge clk);
    #2;
    rst = 1'b0;
    chk(busy === 1'b0 && done === 1'b0 && mode === M_IMM && ctrl_op === C_NONE, "reset state");
    foreach (dirs[i]) run(dirs[i][39:32], dirs[i][31:24], dirs[i][23:16], dirs[i][15:8], dirs[i][0]);
    foreach (ctl_op[i]) run(ctl_op[i], 8'h5A, 8'hA5, 8'h11, 1'b0);
    repeat (150) begin
      seed = xs(seed);
      op = seed[7:0];
      if (op[7:5] == 3'b100) op = ctl_op[seed[31:28] % 13];
      run(op, seed[15:8], seed[23:16], seed[31:24], seed[9]);
    end
    repeat (3) @(posedge clk);
    chk(exq.size() == 0, "missing completions");
    close_out();
  end
endmodule // tb_top
